// File: hdl/fiber_sensor_input_mapper.sv
// Purpose: assembles fiber amplifier outputs into node words for the master
// Assumes: apb slave, ref_clk 50 MHz, srst synchronous active high
// Notes: sensor chain arrives as a parallel sample with a present mask
// How it works
// - mode switch off gives six units on one node, on gives fourteen on two
// - registered amplifier count is held; settings 15 or 16 are an error
// - twin-channel amplifiers count as two units in count and bits
// - narrow mode maps units one to six from the left onto one node
// - narrow word: units in bits 0..5, error bit 6, active bit 7
// - error when count mismatches responders or a fault follows link up
// - active flag set once the link with amplifiers is established
// - wide mode supports fourteen units across two consecutive nodes
// - wide: lower node units 1..8, upper node 9..14 plus flags
// - odd node setting: lower word is setting minus one, upper is setting
// - even node setting: lower word is setting, upper is setting plus one
`timescale 1ns/10ps
module fiber_sensor_input_mapper
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor chain, one bit per unit number
   input wire logic [13:0] unit_sample,
   input wire logic [13:0] unit_present,
   input wire logic link_ready,
   input wire logic link_fault,
   // node words toward the fieldbus side
   output logic [7:0] node_word_lo,
   output logic [7:0] node_word_hi,
   output logic [3:0] node_addr_lo,
   output logic [3:0] node_addr_hi,
   output logic node_pair
);
   // ****************************************
   // helpers
   // ****************************************
   // population count of responders; a twin amplifier presents two bits
   function automatic logic [4:0] count_ones(input logic [13:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 14; i++)
         n = n + {4'h0, v[i]};
      return n;
   endfunction

   function automatic logic [13:0] unit_mask(input logic wide);
      return wide ? 14'h3FFF : 14'h003F;
   endfunction

   // ****************************************
   // control register
   // ****************************************
   logic mode_wide_r;
   logic [4:0] reg_count_r;
   logic [3:0] node_set_r;
   logic cfg_err_r;
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == fiber_map_pkg::off_ctrl) || (paddr == fiber_map_pkg::off_status)
      || (paddr == fiber_map_pkg::off_word_lo) || (paddr == fiber_map_pkg::off_word_hi)
      || (paddr == fiber_map_pkg::off_nodes);

   // settings register; only ctrl is writable
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mode_wide_r <= fiber_map_pkg::ctrl_reset[fiber_map_pkg::ctrl_mode_bit];
         reg_count_r <= fiber_map_pkg::ctrl_reset[fiber_map_pkg::ctrl_count_lsb +: 5];
         node_set_r <= fiber_map_pkg::ctrl_reset[fiber_map_pkg::ctrl_node_lsb +: 4];
      end
      else if (wr_en && paddr == fiber_map_pkg::off_ctrl)
      begin
         mode_wide_r <= pwdata[fiber_map_pkg::ctrl_mode_bit];
         reg_count_r <= pwdata[fiber_map_pkg::ctrl_count_lsb +: 5];
         node_set_r <= pwdata[fiber_map_pkg::ctrl_node_lsb +: 4];
      end
   end

   // count 15 or 16 cannot be wired, so it is flagged as a config fault
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         cfg_err_r <= 1'b0;
      else
         cfg_err_r <= (reg_count_r == fiber_map_pkg::count_bad_lo)
            || (reg_count_r == fiber_map_pkg::count_bad_hi);
   end

   // ****************************************
   // sensor link state
   // ****************************************
   fiber_map_pkg::link_st_t st_r;
   fiber_map_pkg::link_st_t st_nxt;
   logic [4:0] resp_cnt_r;
   logic [13:0] unit_bits_r;
   logic link_err_r;
   logic link_act_r;

   // responders counted per unit number, so twins weigh two
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         resp_cnt_r <= 5'h00;
      else
         resp_cnt_r <= count_ones(unit_present & unit_mask(mode_wide_r));
   end

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         fiber_map_pkg::st_idle:
            if (link_ready)
               st_nxt = fiber_map_pkg::st_wait;
         fiber_map_pkg::st_wait:
            if (!link_ready)
               st_nxt = fiber_map_pkg::st_idle;
            else
               st_nxt = fiber_map_pkg::st_run;
         fiber_map_pkg::st_run:
            if (link_fault || !link_ready)
               st_nxt = fiber_map_pkg::st_fault;
         fiber_map_pkg::st_fault:
            if (!link_ready)
               st_nxt = fiber_map_pkg::st_idle;
         default:
            st_nxt = fiber_map_pkg::st_idle;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         st_r <= fiber_map_pkg::st_idle;
      else
         st_r <= st_nxt;
   end

   // flags follow the link state and the count comparison
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         link_act_r <= 1'b0;
         link_err_r <= 1'b0;
      end
      else
      begin
         link_act_r <= (st_r == fiber_map_pkg::st_run);
         link_err_r <= (st_r == fiber_map_pkg::st_fault) || cfg_err_r
            || (st_r == fiber_map_pkg::st_run && resp_cnt_r != reg_count_r);
      end
   end

   // unit bits resampled every clock; absent or out-of-mode units read zero
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         unit_bits_r <= 14'h0000;
      else
         unit_bits_r <= unit_sample & unit_present & unit_mask(mode_wide_r);
   end

   // ****************************************
   // packing
   // ****************************************
   sensor_if pk_if ();

   node_packer u_packer
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .mode_wide(mode_wide_r),
      .node_set(node_set_r),
      .unit_bits(unit_bits_r),
      .link_err(link_err_r),
      .link_act(link_act_r),
      .pk(pk_if.src)
   );

   assign node_word_lo = pk_if.word_lo;
   assign node_word_hi = pk_if.word_hi;
   assign node_addr_lo = pk_if.node_lo;
   assign node_addr_hi = pk_if.node_hi;
   assign node_pair = mode_wide_r;

   // ****************************************
   // apb answer
   // ****************************************
   // zero wait states; unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            fiber_map_pkg::off_ctrl:
               prdata <= {12'h000, node_set_r, 3'h0, reg_count_r, 7'h00, mode_wide_r};
            fiber_map_pkg::off_status:
               prdata <= {19'h0, resp_cnt_r, 2'h0, st_r, 1'b0, cfg_err_r, link_act_r, link_err_r};
            fiber_map_pkg::off_word_lo:
               prdata <= {24'h000000, pk_if.word_lo};
            fiber_map_pkg::off_word_hi:
               prdata <= {24'h000000, pk_if.word_hi};
            fiber_map_pkg::off_nodes:
               prdata <= {23'h0, mode_wide_r, pk_if.node_hi, pk_if.node_lo};
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_act_from_run;
      @(posedge ref_clk) disable iff (srst)
      (st_r == fiber_map_pkg::st_run) |=> link_act_r;
   endproperty
   a_act_from_run: assert property (p_act_from_run) else $error("active flag missing");

   property p_err_on_fault;
      @(posedge ref_clk) disable iff (srst)
      (st_r == fiber_map_pkg::st_run && link_fault) |=> ##1 link_err_r;
   endproperty
   a_err_on_fault: assert property (p_err_on_fault) else $error("fault not flagged");

   property p_cfg_bad;
      @(posedge ref_clk) disable iff (srst)
      (reg_count_r == fiber_map_pkg::count_bad_lo) |=> ##1 link_err_r;
   endproperty
   a_cfg_bad: assert property (p_cfg_bad) else $error("bad count not flagged");

   property p_narrow_clear;
      @(posedge ref_clk) disable iff (srst)
      !mode_wide_r |=> (unit_bits_r[13:6] == 8'h00);
   endproperty
   a_narrow_clear: assert property (p_narrow_clear) else $error("unused unit bits set");

   property p_resp_count;
      @(posedge ref_clk) disable iff (srst)
      1'b1 |=> (resp_cnt_r == count_ones($past(unit_present) & unit_mask($past(mode_wide_r))));
   endproperty
   a_resp_count: assert property (p_resp_count) else $error("responder count wrong");

   property p_wide_hi_flags;
      @(posedge ref_clk) disable iff (srst)
      mode_wide_r && $past(mode_wide_r) |=> (node_word_hi[7:6] == $past({link_act_r, link_err_r}));
   endproperty
   a_wide_hi_flags: assert property (p_wide_hi_flags) else $error("wide flags misplaced");

   property p_mode_write;
      @(posedge ref_clk) disable iff (srst)
      (wr_en && paddr == fiber_map_pkg::off_ctrl) |=> (mode_wide_r == $past(pwdata[0]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode not taken");

   property p_narrow_one_node;
      @(posedge ref_clk) disable iff (srst)
      !mode_wide_r ##1 !mode_wide_r |=> (node_word_hi == 8'h00 && node_addr_lo == node_addr_hi);
   endproperty
   a_narrow_one_node: assert property (p_narrow_one_node) else $error("narrow uses two nodes");

   c_link_up: cover property (@(posedge ref_clk) disable iff (srst) $rose(link_act_r));
   c_fault: cover property (@(posedge ref_clk) disable iff (srst) st_r == fiber_map_pkg::st_fault);
   c_wide_odd: cover property (@(posedge ref_clk) disable iff (srst) mode_wide_r && node_set_r[0]);
endmodule

// File: include/fiber_map_pkg.sv
// Purpose: constants shared by the fiber sensor input mapper
// Assumes: registers are reached over apb with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package fiber_map_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_status = 8'h04;
   localparam logic [7:0] off_word_lo = 8'h08;
   localparam logic [7:0] off_word_hi = 8'h0C;
   localparam logic [7:0] off_nodes = 8'h10;
   // ctrl field positions
   localparam int ctrl_mode_bit = 0;
   localparam int ctrl_count_lsb = 8;
   localparam int ctrl_node_lsb = 16;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   // ****************************************
   // layout figures
   // ****************************************
   localparam logic [4:0] units_small = 5'h06;
   localparam logic [4:0] units_large = 5'h0E;
   localparam logic [4:0] count_bad_lo = 5'h0F;
   localparam logic [4:0] count_bad_hi = 5'h10;
   localparam int err_bit = 6;
   localparam int act_bit = 7;
   // link state machine, gray along idle, wait, run
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_wait = 2'b01,
      st_run = 2'b11,
      st_fault = 2'b10
   } link_st_t;
endpackage

// File: include/sensor_if.sv
// Purpose: carries packed node words from the packer to the top
// Assumes: one clock domain
// Notes: word_lo is the lower node, word_hi the upper
`timescale 1ns/10ps
interface sensor_if;
   logic [7:0] word_lo;
   logic [7:0] word_hi;
   logic [3:0] node_lo;
   logic [3:0] node_hi;
   modport src (output word_lo, output word_hi, output node_lo, output node_hi);
   modport dst (input word_lo, input word_hi, input node_lo, input node_hi);
endinterface

// File: hdl/node_packer.sv
// Purpose: packs unit bits and link flags into node words
// Assumes: inputs are registered in the top
// Notes: output words are registered
`timescale 1ns/10ps
module node_packer
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // settings
   input wire logic mode_wide,
   input wire logic [3:0] node_set,
   // sensor state
   input wire logic [13:0] unit_bits,
   input wire logic link_err,
   input wire logic link_act,
   // packed words
   sensor_if.src pk
);
   // ****************************************
   // word assembly
   // ****************************************
   // refreshed every clock, so each master read sees the latest sample
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pk.word_lo <= 8'h00;
         pk.word_hi <= 8'h00;
         pk.node_lo <= 4'h0;
         pk.node_hi <= 4'h0;
      end
      else if (!mode_wide)
      begin
         pk.word_lo <= {link_act, link_err, unit_bits[5:0]};
         pk.word_hi <= 8'h00;
         pk.node_lo <= node_set;
         pk.node_hi <= node_set;
      end
      else
      begin
         pk.word_lo <= unit_bits[7:0];
         pk.word_hi <= {link_act, link_err, unit_bits[13:8]};
         if (node_set[0])
         begin
            pk.node_lo <= node_set - 4'h1;
            pk.node_hi <= node_set;
         end
         else
         begin
            pk.node_lo <= node_set;
            pk.node_hi <= node_set + 4'h1;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_odd_pair;
      @(posedge ref_clk) disable iff (srst)
      (mode_wide && node_set[0]) |=> (pk.node_lo == $past(node_set) - 4'h1);
   endproperty
   a_odd_pair: assert property (p_odd_pair) else $error("odd node pairing wrong");

   property p_even_pair;
      @(posedge ref_clk) disable iff (srst)
      (mode_wide && !node_set[0] && node_set != 4'hF) |=> (pk.node_hi == $past(node_set) + 4'h1);
   endproperty
   a_even_pair: assert property (p_even_pair) else $error("even node pairing wrong");

   property p_flags_place;
      @(posedge ref_clk) disable iff (srst)
      !mode_wide |=> (pk.word_lo[7:6] == $past({link_act, link_err}));
   endproperty
   a_flags_place: assert property (p_flags_place) else $error("flags misplaced in narrow word");
endmodule

// File: verif/sensor_chain_model.sv
// Purpose: behavioural chain of fiber amplifiers facing the mapper
// Assumes: bench commands change just after a rising ref_clk edge
// Notes: absent units show a stale high so that masking is exercised
`timescale 1ns/10ps
module sensor_chain_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // commands from the bench
   input wire logic [13:0] on_cmd,
   input wire logic [13:0] present_cmd,
   input wire logic up_cmd,
   input wire logic fault_cmd,
   input wire logic slow,
   // sensor chain pins
   output logic [13:0] unit_sample,
   output logic [13:0] unit_present,
   output logic link_ready,
   output logic link_fault
);
   // ****************************************
   // chain behaviour
   // ****************************************
   logic [3:0] wait_r;
   // a unit that does not answer leaves junk, never a clean zero
   assign unit_sample = on_cmd | ~present_cmd;
   // a twin amplifier answers on two unit numbers
   assign unit_present = present_cmd;
   // a fault only means something once the link is up
   assign link_fault = fault_cmd & link_ready;
   // link handshake, short or long, restarts whenever up_cmd drops
   always_ff @(posedge ref_clk)
   begin
      if (srst || !up_cmd)
      begin
         wait_r <= 4'h0;
         link_ready <= 1'b0;
      end
      else if (wait_r == (slow ? 4'h9 : 4'h2))
         link_ready <= 1'b1;
      else
         wait_r <= wait_r + 4'h1;
   end
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for the fiber sensor input mapper
// Assumes: zero-wait apb slave, link flags settle within 20 clocks
// Notes: expected words are rebuilt here from the commanded chain
`timescale 1ns/10ps
module tb;
   // ****************************************
   // signals and instances
   // ****************************************
   logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, err_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] unit_sample, unit_present, on_cmd, present_cmd;
   logic link_ready, link_fault, up_cmd, fault_cmd, slow, node_pair;
   logic [7:0] node_word_lo, node_word_hi;
   logic [3:0] node_addr_lo, node_addr_hi;
   int mismatches, samples_checked;
   fiber_sensor_input_mapper uut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .unit_sample(unit_sample), .unit_present(unit_present),
      .link_ready(link_ready), .link_fault(link_fault), .node_word_lo(node_word_lo),
      .node_word_hi(node_word_hi), .node_addr_lo(node_addr_lo), .node_addr_hi(node_addr_hi),
      .node_pair(node_pair));
   sensor_chain_model chain (.ref_clk(ref_clk), .srst(srst), .on_cmd(on_cmd),
      .present_cmd(present_cmd), .up_cmd(up_cmd), .fault_cmd(fault_cmd), .slow(slow),
      .unit_sample(unit_sample), .unit_present(unit_present), .link_ready(link_ready),
      .link_fault(link_fault));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) mismatches++; // a slave that never answers fails the run
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic mode, input logic [4:0] cnt, input logic [3:0] node,
      input logic [13:0] on, input logic [13:0] pres);
      apb(1'b1, fiber_map_pkg::off_ctrl, (32'(mode) << fiber_map_pkg::ctrl_mode_bit)
         | (32'(cnt) << fiber_map_pkg::ctrl_count_lsb) | (32'(node) << fiber_map_pkg::ctrl_node_lsb));
      on_cmd <= on;
      present_cmd <= pres;
      up_cmd <= 1'b0;
      settle(3);
      up_cmd <= 1'b1;
      settle(20);
   endtask
   // rebuild both node words from the chain state and compare
   task automatic expect_words(input logic mode, input logic [3:0] node, input logic err,
      input logic act);
      logic [13:0] m;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [3:0] nlo;
      m = on_cmd & present_cmd;
      lo = mode ? m[7:0] : {act, err, m[5:0]};
      hi = mode ? {act, err, m[13:8]} : 8'h00;
      nlo = (mode && node[0]) ? node - 4'h1 : node;
      chk({24'h0, node_word_lo}, {24'h0, lo});
      chk({24'h0, node_word_hi}, {24'h0, hi});
      chk({28'h0, node_addr_lo}, {28'h0, nlo});
      chk({28'h0, node_addr_hi}, {28'h0, mode ? nlo + 4'h1 : node});
      chk({31'h0, node_pair}, {31'h0, mode});
      apb(1'b0, fiber_map_pkg::off_word_hi, 32'h0);
      chk(rd, {24'h0, hi});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      chk({16'h0000, node_word_hi, node_word_lo}, 32'h0);
      apb(1'b0, fiber_map_pkg::off_ctrl, 32'h0);
      chk(rd, fiber_map_pkg::ctrl_reset);
   endtask
   task automatic t_narrow;
      cfg(1'b0, 5'h06, 4'h5, 14'h3F15, 14'h003F);
      expect_words(1'b0, 4'h5, 1'b0, 1'b1);
      on_cmd <= 14'h002A;
      settle(4);
      expect_words(1'b0, 4'h5, 1'b0, 1'b1);
      cfg(1'b0, 5'h05, 4'h5, 14'h3FFF, 14'h001F);
      expect_words(1'b0, 4'h5, 1'b0, 1'b1);
   endtask
   task automatic t_count;
      logic [4:0] bad [2];
      bad = '{fiber_map_pkg::count_bad_lo, fiber_map_pkg::count_bad_hi};
      cfg(1'b0, 5'h04, 4'h3, 14'h0015, 14'h003F);
      expect_words(1'b0, 4'h3, 1'b1, 1'b1);
      foreach (bad[i])
      begin
         cfg(1'b1, bad[i], 4'h3, 14'h1234, 14'h3FFF);
         chk({31'h0, node_word_hi[6]}, 32'h1);
      end
   endtask
   task automatic t_wide;
      logic [3:0] nodes [4];
      nodes = '{4'h1, 4'h4, 4'h7, 4'hE};
      slow <= 1'b1;
      foreach (nodes[i])
      begin
         cfg(1'b1, 5'h0E, nodes[i], 14'h2C93 ^ 14'(i), 14'h3FFF);
         expect_words(1'b1, nodes[i], 1'b0, 1'b1);
      end
      slow <= 1'b0;
   endtask
   task automatic t_fault;
      cfg(1'b1, 5'h0E, 4'h9, 14'h0F0F, 14'h3FFF);
      fault_cmd <= 1'b1;
      settle(4);
      chk({31'h0, node_word_hi[6]}, 32'h1);
      apb(1'b0, fiber_map_pkg::off_status, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      fault_cmd <= 1'b0;
   endtask
   // unmapped and read-only places must leave the settings alone
   task automatic t_apb_err;
      apb(1'b1, fiber_map_pkg::off_ctrl, 32'h0002_0601);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err_seen}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      apb(1'b1, fiber_map_pkg::off_status, 32'hFFFF_FFFF);
      apb(1'b0, fiber_map_pkg::off_ctrl, 32'h0);
      chk(rd, 32'h0002_0601);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // clock, watchdog and main sequence
   // ****************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // whole run needs well under 2000 clocks
   initial
   begin
      settle(20000);
      mismatches++;
      tally_and_finish();
   end
   initial
   begin
      mismatches = 0;
      samples_checked = 0;
      srst = 1'b1;
      {psel, penable, pwrite, up_cmd, fault_cmd, slow} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      on_cmd = 14'h0;
      present_cmd = 14'h0;
      settle(8);
      srst <= 1'b0;
      settle(1);
      t_reset();
      t_narrow();
      t_count();
      t_wide();
      t_fault();
      t_apb_err();
      tally_and_finish();
   end
endmodule
